// [src/reset_state_map.svh]
// constants for the reset, power-up and warm-restart state loader
`ifndef RESET_STATE_MAP_SVH
`define RESET_STATE_MAP_SVH

`define N_SIMD           8
`define N_VEC            8
`define N_GPHI           8
`define N_PMC            2
`define HAS_VECTOR       1'b1
`define HAS_EXT64        1'b1
`define SIMD_RESET       64'h0000_0000_0000_0000
`define VEC_RESET        128'h0
`define GP_RESET         64'h0000_0000_0000_0000
`define VCSR_RESET       32'h0000_1f80
`define CTRL0_POWERUP    32'h6000_0010
`define CTRL0_KEEP_MASK  32'h6000_0000
`define CTRL0_FORCE_SET  32'h0000_0010
`define FLAGS_RESET      32'h0000_0002
`define FPU_CW_RESET     16'h0040
`define ACC_RESET        32'h0000_0000
`define COUNT_RESET      64'h0000_0000_0000_0000
`define EVSEL_EN_BIT     0
`define MISC_DCACHE_BIT  0
`define MISC_CCACHE_BIT  1
`define MISC_TLB_BIT     2
`define MISC_FMTRR_BIT   3
`define MISC_VMTRR_BIT   4
`define MISC_LAPIC_BIT   5
`define BUILTIN_SELF_TEST_CYCLES      8'h20
`define BUILTIN_SELF_TEST_SEED        16'hace1
`define BUILTIN_SELF_TEST_FAIL_CODE   32'h0000_0001

`endif

// [src/reset_state_pkg.sv]
// types shared by the state loader, its checker and its bench
`include "reset_state_map.svh"
package reset_state_pkg;

  typedef enum logic [3:0] {
    ST_RUN      = 4'h1,
    ST_APPLY    = 4'h2,
    ST_SELFTEST = 4'h4,
    ST_IDLE     = 4'h8
  } state_e;

  typedef enum logic [1:0] {
    CAUSE_POWERUP = 2'h0,
    CAUSE_HWRESET = 2'h1,
    CAUSE_WARM    = 2'h2
  } cause_e;

  typedef enum logic [3:0] {
    GRP_SIMD  = 4'h0,
    GRP_VLO   = 4'h1,
    GRP_VHI   = 4'h2,
    GRP_GPHI  = 4'h3,
    GRP_VCSR  = 4'h4,
    GRP_CTRL0 = 4'h5,
    GRP_FLAGS = 4'h6,
    GRP_FPUCW = 4'h7,
    GRP_PMC   = 4'h8,
    GRP_MISC  = 4'h9
  } grp_e;

  typedef struct packed {
    logic powerUp;
    logic hwReset;
    logic warmInit;
  } init_req_s;

  typedef struct packed {
    logic         en;
    grp_e         grp;
    logic [3:0]   idx;
    logic [127:0] data;
  } state_wr_s;

  typedef struct packed {
    grp_e       grp;
    logic [3:0] idx;
  } state_rd_s;

endpackage

// [src/builtin_self_test_engine.sv]
// built-in self-test engine: pattern echo check over a fixed run
`timescale 1ns/1ps
`default_nettype none
`include "reset_state_map.svh"
module builtin_self_test_engine (
  input  wire logic        ref_clk,     // core clock
  input  wire logic        reset,       // synchronous, active high
  input  wire logic        start,       // one-cycle launch, restarts a run
  input  wire logic        faultInject, // flips echo bit 0 while high
  output var  logic        done_q,      // one-cycle end of run
  output var  logic [31:0] result_q     // zero only on a clean run
);
  logic [15:0] pattern_q;
  logic [15:0] echo_q;
  logic [7:0]  count_q;
  logic        busy_q;
  logic        fail_q;

  wire         lastStep = busy_q & (count_q == `BUILTIN_SELF_TEST_CYCLES - 8'h01);
  wire         miscmp   = busy_q & (echo_q != pattern_q);
  wire [15:0]  lfsrNext = {pattern_q[14:0],
                           pattern_q[15] ^ pattern_q[13] ^
                           pattern_q[12] ^ pattern_q[10]};

  always_ff @(posedge ref_clk) begin
    if (reset | start) begin
      pattern_q <= `BUILTIN_SELF_TEST_SEED;
      echo_q    <= `BUILTIN_SELF_TEST_SEED;
      count_q   <= 8'h00;
      busy_q    <= start & ~reset;
      fail_q    <= 1'b0;
      done_q    <= 1'b0;
      result_q  <= `ACC_RESET;
    end else if (busy_q) begin
      pattern_q <= lfsrNext;
      echo_q    <= lfsrNext ^ {15'h0000, faultInject};
      count_q   <= count_q + 8'h01;
      busy_q    <= ~lastStep;
      fail_q    <= fail_q | miscmp;
      done_q    <= lastStep;
      // any miscompare anywhere in the run forces a nonzero code
      result_q  <= (fail_q | miscmp) ? `BUILTIN_SELF_TEST_FAIL_CODE : `ACC_RESET;
    end else begin
      done_q    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [src/processor_reset_state_init.sv]
// architectural state loader for power-up, hardware reset and warm restart
`timescale 1ns/1ps
`default_nettype none
`include "reset_state_map.svh"
module processor_reset_state_init
  import reset_state_pkg::*;
(
  input  wire logic         ref_clk,          // core clock, 200 MHz
  input  wire logic         reset,            // sync, high; acts as power-up
  input  wire init_req_s    initReq,          // one-cycle cause pulses
  input  wire logic         bistEnable,       // self-test on cold start
  input  wire logic         bistFaultInject,  // forces a self-test failure
  input  wire logic [1:0]   perfEvent,        // per-counter event strobes
  input  wire state_wr_s    stateWr,          // state write, taken when ready
  input  wire state_rd_s    stateRd,          // state read select
  output var  logic [127:0] rdData_q,         // read data, one cycle later
  output var  logic         ready_q,          // sequence done, core may run
  output var  cause_e       lastCause_q,      // cause of last sequence
  output var  logic [31:0]  ctrlRegZero_q,    // control register zero
  output var  logic [31:0]  flagsWord_q,      // flags word
  output var  logic [31:0]  accumulatorReg_q, // accumulator / self-test code
  output var  logic [31:0]  vectorCtrlStatus_q, // vector control/status
  output var  logic [63:0]  timeStamp_q,      // timestamp counter
  output var  logic [2:0]   cacheValid_q,     // data, code, tlb valid
  output var  logic         fixedMtrrEn_q,    // fixed range regs enabled
  output var  logic         varMtrrEn_q,      // variable range regs enabled
  output var  logic         localIntrCtrlEn_q // local intr controller enabled
);
  state_e       state_q;
  state_e       state_d;
  logic [63:0]  simdIntRegs_q    [`N_SIMD];
  logic [127:0] vectorRegsLow_q  [`N_VEC];
  logic [127:0] vectorRegsHigh_q [`N_VEC];
  logic [63:0]  upperGpRegs_q    [`N_GPHI];
  logic [63:0]  perfCount_q      [`N_PMC];
  logic [63:0]  eventSel_q       [`N_PMC];
  logic [15:0]  fpuCtrlWord_q;
  logic         bistDone;
  logic [31:0]  bistResult;

  function automatic logic wr_hit(input state_wr_s w, input grp_e g,
                                  input int i, input logic ok);
    wr_hit = ok & w.en & (w.grp == g) & (w.idx == 4'(i));
  endfunction

  function automatic logic [127:0] zext64(input logic [63:0] v);
    zext64 = {64'h0, v};
  endfunction

  // cause decode: power-up outranks hardware reset outranks warm restart
  wire    coldReq   = initReq.powerUp | initReq.hwReset;
  wire    takeCold  = coldReq &
                      ((state_q == ST_RUN) | (state_q == ST_SELFTEST));
  wire    takeWarm  = initReq.warmInit & ~coldReq & (state_q == ST_RUN);
  wire    takeAny   = takeCold | takeWarm;
  wire cause_e causeIn = initReq.powerUp ? CAUSE_POWERUP :
                         initReq.hwReset ? CAUSE_HWRESET :
                         CAUSE_WARM;
  wire    applying  = (state_q == ST_APPLY);
  wire    coldApply = applying & (lastCause_q != CAUSE_WARM);
  wire    powerApply = applying & (lastCause_q == CAUSE_POWERUP);
  // a warm restart never launches self-test
  wire    bistStart = coldApply & bistEnable;
  wire    wrOk      = (state_q == ST_RUN);
  wire    vecOk     = wrOk & `HAS_VECTOR;
  wire    gpOk      = wrOk & `HAS_EXT64;
  wire [31:0] ctrl0Kept = (ctrlRegZero_q & `CTRL0_KEEP_MASK) |
                          `CTRL0_FORCE_SET;
  wire [127:0] vecLoRd = `HAS_VECTOR ? vectorRegsLow_q[stateRd.idx[2:0]]
                                     : `VEC_RESET;
  wire [127:0] vecHiRd = (`HAS_VECTOR & `HAS_EXT64)
                         ? vectorRegsHigh_q[stateRd.idx[2:0]] : `VEC_RESET;
  wire [127:0] gpHiRd  = `HAS_EXT64 ? zext64(upperGpRegs_q[stateRd.idx[2:0]])
                                    : `VEC_RESET;
  wire [63:0]  pmcRd   = stateRd.idx[1] ? eventSel_q[stateRd.idx[0]]
                                        : perfCount_q[stateRd.idx[0]];
  wire [5:0]   miscRd  = {localIntrCtrlEn_q, varMtrrEn_q, fixedMtrrEn_q,
                          cacheValid_q};
  wire [127:0] rdSel =
    (stateRd.grp == GRP_SIMD)  ? zext64(simdIntRegs_q[stateRd.idx[2:0]]) :
    (stateRd.grp == GRP_VLO)   ? vecLoRd :
    (stateRd.grp == GRP_VHI)   ? vecHiRd :
    (stateRd.grp == GRP_GPHI)  ? gpHiRd :
    (stateRd.grp == GRP_VCSR)  ? {96'h0, vectorCtrlStatus_q} :
    (stateRd.grp == GRP_CTRL0) ? {96'h0, ctrlRegZero_q} :
    (stateRd.grp == GRP_FLAGS) ? {96'h0, flagsWord_q} :
    (stateRd.grp == GRP_FPUCW) ? {112'h0, fpuCtrlWord_q} :
    (stateRd.grp == GRP_PMC)   ? zext64(pmcRd) :
    (stateRd.grp == GRP_MISC)  ? {122'h0, miscRd} : 128'h0;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN:      if (takeAny) state_d = ST_APPLY;
      ST_APPLY:    state_d = bistStart ? ST_SELFTEST : ST_RUN;
      ST_SELFTEST: begin
        if (takeCold) state_d = ST_APPLY;
        else if (bistDone) state_d = ST_RUN;
      end
      default:     state_d = ST_APPLY;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q     <= ST_APPLY;
      lastCause_q <= CAUSE_POWERUP;
      ready_q     <= 1'b0;
      rdData_q    <= 128'h0;
    end else begin
      state_q     <= state_d;
      if (takeAny) lastCause_q <= causeIn;
      ready_q     <= (state_d == ST_RUN);
      rdData_q    <= rdSel;
    end
  end

  // no reset on the arrays but the counters: the apply cycle right after reset clears them
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < `N_SIMD; i++) begin
      if (coldApply) simdIntRegs_q[i] <= `SIMD_RESET;
      else if (wr_hit(stateWr, GRP_SIMD, i, wrOk))
        simdIntRegs_q[i] <= stateWr.data[63:0];
    end
    for (int i = 0; i < `N_VEC; i++) begin
      if (coldApply) vectorRegsLow_q[i] <= `VEC_RESET;
      else if (wr_hit(stateWr, GRP_VLO, i, vecOk))
        vectorRegsLow_q[i] <= stateWr.data;
      if (coldApply) vectorRegsHigh_q[i] <= `VEC_RESET;
      else if (wr_hit(stateWr, GRP_VHI, i, vecOk & `HAS_EXT64))
        vectorRegsHigh_q[i] <= stateWr.data;
    end
    for (int i = 0; i < `N_GPHI; i++) begin
      // cleared by every sequence, warm restart included
      if (applying) upperGpRegs_q[i] <= `GP_RESET;
      else if (wr_hit(stateWr, GRP_GPHI, i, gpOk))
        upperGpRegs_q[i] <= stateWr.data[63:0];
    end
    for (int i = 0; i < `N_PMC; i++) begin
      if (reset | coldApply) begin
        perfCount_q[i] <= `COUNT_RESET;
        eventSel_q[i]  <= `COUNT_RESET;
      end else begin
        if (wr_hit(stateWr, GRP_PMC, i, wrOk))
          perfCount_q[i] <= stateWr.data[63:0];
        else if (eventSel_q[i][`EVSEL_EN_BIT] & perfEvent[i])
          perfCount_q[i] <= perfCount_q[i] + 64'h1;
        if (wr_hit(stateWr, GRP_PMC, i + 2, wrOk))
          eventSel_q[i] <= stateWr.data[63:0];
      end
    end
  end

  // only power-up forces the whole word; other causes keep the cache flags
  always_ff @(posedge ref_clk) begin
    if (reset | powerApply) begin
      ctrlRegZero_q <= `CTRL0_POWERUP;
    end else if (applying) begin
      ctrlRegZero_q <= ctrl0Kept;
    end else if (wr_hit(stateWr, GRP_CTRL0, 0, wrOk)) begin
      ctrlRegZero_q <= stateWr.data[31:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset | applying) begin
      // upper ten bits driven to zero but left open to software
      flagsWord_q <= `FLAGS_RESET;
    end else if (wr_hit(stateWr, GRP_FLAGS, 0, wrOk)) begin
      flagsWord_q <= stateWr.data[31:0];
    end
  end

  // a cold cause during self-test restarts it, so a stale result is dropped
  always_ff @(posedge ref_clk) begin
    if (reset | applying) begin
      accumulatorReg_q <= `ACC_RESET;
    end else if ((state_q == ST_SELFTEST) & bistDone & ~takeCold) begin
      accumulatorReg_q <= bistResult;
    end
  end

  // warm restart falls through: caches, ranges and intr enable are kept
  always_ff @(posedge ref_clk) begin
    if (reset | coldApply) begin
      vectorCtrlStatus_q <= `VCSR_RESET;
      fpuCtrlWord_q      <= `FPU_CW_RESET;
      cacheValid_q       <= 3'h0;
      fixedMtrrEn_q      <= 1'b0;
      varMtrrEn_q        <= 1'b0;
      localIntrCtrlEn_q  <= 1'b1;
    end else begin
      if (wr_hit(stateWr, GRP_VCSR, 0, vecOk))
        vectorCtrlStatus_q <= stateWr.data[31:0];
      if (wr_hit(stateWr, GRP_FPUCW, 0, wrOk))
        fpuCtrlWord_q <= stateWr.data[15:0];
      if (wr_hit(stateWr, GRP_MISC, 0, wrOk)) begin
        cacheValid_q      <= stateWr.data[`MISC_TLB_BIT:`MISC_DCACHE_BIT];
        fixedMtrrEn_q     <= stateWr.data[`MISC_FMTRR_BIT];
        varMtrrEn_q       <= stateWr.data[`MISC_VMTRR_BIT];
        localIntrCtrlEn_q <= stateWr.data[`MISC_LAPIC_BIT];
      end
    end
  end

  // free-running; a warm restart must not disturb the count
  always_ff @(posedge ref_clk) begin
    if (reset | coldApply) timeStamp_q <= `COUNT_RESET;
    else timeStamp_q <= timeStamp_q + 64'h1;
  end

  builtin_self_test_engine selfTest (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .start       (bistStart),
    .faultInject (bistFaultInject),
    .done_q      (bistDone),
    .result_q    (bistResult)
  );
endmodule
`default_nettype wire

// [tb/reset_state_init_properties.sv]
// checker watching the state loader's outputs around each init cause
`timescale 1ns/1ps
`default_nettype none
module reset_state_init_checker
  import reset_state_pkg::*;
(
  input wire logic        ref_clk,            // clock
  input wire logic        reset,              // sync reset
  input wire init_req_s   initReq,            // cause pulses
  input wire logic        ready_q,            // run level
  input wire cause_e      lastCause_q,        // last cause
  input wire logic [31:0] ctrlRegZero_q,      // control reg zero
  input wire logic [31:0] vectorCtrlStatus_q, // vector ctrl/status
  input wire logic [63:0] timeStamp_q,        // timestamp
  input wire logic [2:0]  cacheValid_q,       // cache valid bits
  input wire logic        fixedMtrrEn_q,      // fixed range enable
  input wire logic        varMtrrEn_q,        // var range enable
  input wire logic        localIntrCtrlEn_q   // intr ctrl enable
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  logic readyWas_q;
  wire coldReq = initReq.powerUp | initReq.hwReset;
  wire warmTake = ready_q & initReq.warmInit & ~coldReq;
  wire keepTake = ready_q & ~initReq.powerUp & (initReq.hwReset | warmTake);
  wire [1:0] causeCode = initReq.powerUp ? 2'h0 :
                         initReq.hwReset ? 2'h1 : 2'h2;
  // rise of ready after any cold sequence, arrays loaded at that point
  wire coldUp = ready_q & ~readyWas_q & (lastCause_q != CAUSE_WARM);
  always_ff @(posedge ref_clk) begin
    readyWas_q <= ready_q;
  end
  chk_cause_taken: assert property (ready_q && (coldReq || initReq.warmInit)
    |=> !ready_q && lastCause_q == $past(causeCode))
    else $error("cause not taken as expected");
  chk_warm_vcsr_kept: assert property (warmTake |-> ##2
    vectorCtrlStatus_q == $past(vectorCtrlStatus_q, 2))
    else $error("vector status changed by warm restart");
  chk_warm_cache_kept: assert property (warmTake |-> ##2
    cacheValid_q == $past(cacheValid_q, 2))
    else $error("cache valid changed by warm restart");
  chk_warm_misc_kept: assert property (warmTake |-> ##2
    {fixedMtrrEn_q, varMtrrEn_q, localIntrCtrlEn_q}
    == $past({fixedMtrrEn_q, varMtrrEn_q, localIntrCtrlEn_q}, 2))
    else $error("range or intr enables changed by warm restart");
  chk_warm_tsc_runs: assert property (warmTake |-> ##2
    timeStamp_q > $past(timeStamp_q, 2))
    else $error("timestamp cleared by warm restart");
  chk_warm_no_selftest: assert property (warmTake |-> ##2 ready_q)
    else $error("warm restart did not return at once");
  chk_cold_vcsr: assert property (coldUp |->
    vectorCtrlStatus_q == 32'h0000_1f80)
    else $error("vector status not loaded on cold start");
  chk_cold_cache_inv: assert property (coldUp |->
    cacheValid_q == 3'h0)
    else $error("caches valid after cold start");
  chk_cold_misc: assert property (coldUp |->
    !fixedMtrrEn_q && !varMtrrEn_q && localIntrCtrlEn_q)
    else $error("range or intr enables wrong after cold start");
  chk_cold_tsc_clear: assert property (coldUp |->
    timeStamp_q < 64'h40)
    else $error("timestamp not cleared on cold start");
  chk_power_ctrl0: assert property (
    coldUp && lastCause_q == CAUSE_POWERUP |-> ctrlRegZero_q == 32'h6000_0010)
    else $error("control reg zero wrong after power-up");
  chk_keep_ctrl0_flags: assert property (keepTake |-> ##2
    ctrlRegZero_q == (($past(ctrlRegZero_q, 2) & 32'h6000_0000)
    | 32'h0000_0010))
    else $error("control reg zero cache flags not kept");
endmodule
`default_nettype wire

// [tb/platform_init_model.sv]
// platform side: turns a cause request into a one-cycle cause pulse
`timescale 1ns/1ps
`default_nettype none
module platform_init_model
  import reset_state_pkg::*;
(
  input  wire logic   fire,   // high for one cycle per event
  input  wire cause_e kind,   // which cause to signal
  output var  init_req_s initReq // pulses into the loader
);
  // one cause at a time; priority clashes are not exercised here
  always_comb begin
    initReq = '0;
    initReq.powerUp = fire & (kind == CAUSE_POWERUP);
    initReq.hwReset = fire & (kind == CAUSE_HWRESET);
    initReq.warmInit = fire & (kind == CAUSE_WARM);
  end
endmodule
`default_nettype wire

// [tb/tb_processor_reset_state_init.sv]
// self-checking bench for the power-up, reset and warm-restart loader
`timescale 1ns/1ps
`default_nettype none
module tb_processor_reset_state_init
  import reset_state_pkg::*;
;
  logic ref_clk = 1'b0, reset = 1'b1, fire = 1'b0;
  logic bistEnable = 1'b0, bistFaultInject = 1'b0;
  logic [1:0] perfEvent = 2'h0;
  cause_e kind = CAUSE_WARM;
  state_wr_s stateWr = '0;
  state_rd_s stateRd = '0;
  init_req_s initReq;
  logic [127:0] rdData_q;
  logic ready_q, fixedMtrrEn_q, varMtrrEn_q, localIntrCtrlEn_q;
  cause_e lastCause_q;
  logic [31:0] ctrlRegZero_q, flagsWord_q;
  logic [31:0] accumulatorReg_q, vectorCtrlStatus_q;
  logic [63:0] timeStamp_q;
  logic [2:0] cacheValid_q;
  int error_cnt = 0, n_tests = 0, lat;
  always #2.5 ref_clk = ~ref_clk;
  platform_init_model plat (.fire, .kind, .initReq);
  processor_reset_state_init dut (.ref_clk, .reset, .initReq, .bistEnable,
    .bistFaultInject, .perfEvent, .stateWr, .stateRd, .rdData_q, .ready_q,
    .lastCause_q, .ctrlRegZero_q, .flagsWord_q, .accumulatorReg_q,
    .vectorCtrlStatus_q, .timeStamp_q, .cacheValid_q, .fixedMtrrEn_q,
    .varMtrrEn_q, .localIntrCtrlEn_q);
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input grp_e g, input logic [3:0] i, input logic [127:0] d);
    @(negedge ref_clk) stateWr = '{1'b1, g, i, d};
    @(negedge ref_clk) stateWr.en = 1'b0;
  endtask
  // read data is registered, so data is looked at one cycle later
  task automatic rd(input grp_e g, input logic [3:0] i, input logic [127:0] e);
    @(negedge ref_clk) stateRd = '{g, i};
    @(negedge ref_clk) chk(rdData_q, e);
  endtask
  task automatic wait_ready();
    lat = 1;
    while (ready_q !== 1'b1 && lat < 200) begin
      @(negedge ref_clk);
      lat++;
    end
    if (lat >= 200) error_cnt++;
  endtask
  task automatic cause(input cause_e k);
    @(negedge ref_clk) begin
      kind = k;
      fire = 1'b1;
    end
    @(negedge ref_clk) fire = 1'b0;
    wait_ready();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    wait_ready();
    chk(ctrlRegZero_q, 32'h6000_0010);
    chk(vectorCtrlStatus_q, 32'h0000_1f80);
    chk(flagsWord_q[21:0], 22'h2);
    chk({cacheValid_q, fixedMtrrEn_q, varMtrrEn_q}, 5'h0);
    chk(localIntrCtrlEn_q, 1'b1);
    chk(accumulatorReg_q, 32'h0);
    rd(GRP_SIMD, 4'h7, '0);
    rd(GRP_VLO, 4'h0, '0);
    rd(GRP_VHI, 4'h7, '0);
    rd(GRP_GPHI, 4'h7, '0);
    rd(GRP_PMC, 4'h2, '0);
    $display("test power-up defaults done");
    perfEvent = 2'h1;
    wr(GRP_SIMD, 4'h7, 128'h0123_4567_89ab_cdef);
    wr(GRP_VLO, 4'h0, {4{32'hdead_beef}});
    wr(GRP_VHI, 4'h7, {4{32'h5a5a_a5a5}});
    wr(GRP_GPHI, 4'h7, 128'h77);
    wr(GRP_VCSR, 4'h0, 128'h1234);
    wr(GRP_FPUCW, 4'h0, 128'h037f);
    wr(GRP_PMC, 4'h2, 128'h1);
    wr(GRP_MISC, 4'h0, 128'h1f);
    wr(GRP_CTRL0, 4'h0, 128'hffff_ffff);
    wr(GRP_FLAGS, 4'h0, 128'h0000_0ed7);
    perfEvent = 2'h0;
    wr(GRP_PMC, 4'h0, 128'h55);
    bistEnable = 1'b1;
    cause(CAUSE_WARM);
    chk(lat == 2, 1'b1);
    chk(lastCause_q, CAUSE_WARM);
    chk(ctrlRegZero_q, 32'h6000_0010);
    chk(vectorCtrlStatus_q, 32'h1234);
    chk({localIntrCtrlEn_q, varMtrrEn_q, fixedMtrrEn_q, cacheValid_q},
        6'h1f);
    rd(GRP_SIMD, 4'h7, 128'h0123_4567_89ab_cdef);
    rd(GRP_FPUCW, 4'h0, 128'h037f);
    rd(GRP_VLO, 4'h0, {4{32'hdead_beef}});
    rd(GRP_VHI, 4'h7, {4{32'h5a5a_a5a5}});
    rd(GRP_GPHI, 4'h7, '0);
    rd(GRP_PMC, 4'h2, 128'h1);
    chk(flagsWord_q[21:0], 22'h2);
    rd(GRP_PMC, 4'h0, 128'h55);
    perfEvent = 2'h1;
    @(negedge ref_clk) perfEvent = 2'h0;
    rd(GRP_PMC, 4'h0, 128'h56);
    $display("test warm restart done");
    bistEnable = 1'b0;
    wr(GRP_CTRL0, 4'h0, 128'h2000_00ff);
    cause(CAUSE_HWRESET);
    chk(timeStamp_q[63:4], 60'h0);
    chk(lastCause_q, CAUSE_HWRESET);
    chk(ctrlRegZero_q, 32'h2000_0010);
    chk(vectorCtrlStatus_q, 32'h0000_1f80);
    chk({localIntrCtrlEn_q, varMtrrEn_q, fixedMtrrEn_q, cacheValid_q},
        6'h20);
    rd(GRP_SIMD, 4'h7, '0);
    rd(GRP_VLO, 4'h0, '0);
    rd(GRP_VHI, 4'h7, '0);
    rd(GRP_PMC, 4'h2, '0);
    rd(GRP_PMC, 4'h0, '0);
    $display("test hardware reset done");
    bistEnable = 1'b1;
    bistFaultInject = 1'b1;
    cause(CAUSE_POWERUP);
    chk(lat > 30, 1'b1);
    chk(accumulatorReg_q, 32'h1);
    chk(ctrlRegZero_q, 32'h6000_0010);
    bistFaultInject = 1'b0;
    cause(CAUSE_POWERUP);
    chk(accumulatorReg_q, 32'h0);
    chk(lastCause_q, CAUSE_POWERUP);
    $display("test self-test outcome done");
    tally_and_finish();
  end
endmodule
bind processor_reset_state_init reset_state_init_checker chk_i (.ref_clk,
  .reset, .initReq, .ready_q, .lastCause_q, .ctrlRegZero_q,
  .vectorCtrlStatus_q, .timeStamp_q, .cacheValid_q, .fixedMtrrEn_q,
  .varMtrrEn_q, .localIntrCtrlEn_q);
`default_nettype wire
